// ==== adcrc_regs.svh ====
`ifndef ADCRC_REGS_SVH
`define ADCRC_REGS_SVH

// Slot control entry layout
`define ADCRC_CH_LSB 0
`define ADCRC_CH_MSB 3
`define ADCRC_SREF_LSB 4
`define ADCRC_SREF_MSB 6
`define ADCRC_EOS_BIT 7
`define ADCRC_CTL_RESET 8'h00

// Channel codes: last external input, then the internal inputs
`define ADCRC_CH_LAST_EXT 4'h7
`define ADCRC_CH_TEMP 4'ha
`define ADCRC_CH_HALF_SUPPLY 4'hb

// Result and storage sizes
`define ADCRC_RESULT_BITS 12
`define ADCRC_SAR_MSB_IDX 4'hb
`define ADCRC_SAR_MID 12'h800
`define ADCRC_RESULT_RESET 12'h000
`define ADCRC_SLOTS 16
`define ADCRC_FIFO_DEPTH 8
`define ADCRC_FIFO_WIDTH 16

// Timing: comparator settle time after each trial code
`define ADCRC_MCLK_NS 50
`define ADCRC_SETTLE_NS 150
`define ADCRC_SETTLE_CYC ((`ADCRC_SETTLE_NS + `ADCRC_MCLK_NS - 1) / `ADCRC_MCLK_NS)
// Dedicated oscillator modelled as mclk divided by this count
`define ADCRC_OSC_DIV 3'h4

`endif

// ==== adcrc_pkg.sv ====
package adcrc_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SAMPLE = 3'b001,
    ST_CONVERT = 3'b010,
    ST_STORE = 3'b011,
    ST_ARM = 3'b100
  } adcrc_state_t;

  typedef enum logic [1:0] {
    MODE_SINGLE = 2'b00,
    MODE_SEQ_ONCE = 2'b01,
    MODE_REP_SINGLE = 2'b10,
    MODE_REP_SEQ = 2'b11
  } adcrc_mode_t;

  typedef enum logic [1:0] {
    CLK_OSC = 2'b00,
    CLK_MCLK = 2'b01,
    CLK_AUX = 2'b10,
    CLK_SUB = 2'b11
  } adcrc_clksel_t;

  typedef struct packed {
    logic eos;
    logic [2:0] sref;
    logic [3:0] chan;
  } adcrc_slot_ctl_t;

endpackage

// ==== adcrc_stream_if.sv ====
`timescale 1ns/1ns
interface adcrc_stream_if #(parameter int W = 16);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface

// ==== adcrc_fifo.sv ====
`timescale 1ns/1ns
module adcrc_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 8
) (
  input wire logic mclk,
  input wire logic reset_n,
  adcrc_stream_if.snk inPort,
  output logic outValid,
  input wire logic outReady,
  output logic [W-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] count;
    logic outValid;
    logic [W-1:0] outData;
  } adcrc_fifo_state_t;

  adcrc_fifo_state_t st_reg;
  adcrc_fifo_state_t st_next;
  logic push;
  logic pop;

  // Full is honest: ready drops once every word is taken
  assign inPort.ready = (st_reg.count != (AW+1)'(DEPTH));
  assign push = inPort.valid && inPort.ready;
  assign pop = (st_reg.count != '0) && (!st_reg.outValid || outReady);
  assign outValid = st_reg.outValid;
  assign outData = st_reg.outData;

  // Output word is a register so the reader sees no memory path
  always_comb
  begin
    st_next = st_reg;
    if (outReady && st_reg.outValid)
    begin
      st_next.outValid = 1'b0;
    end
    if (pop)
    begin
      st_next.outValid = 1'b1;
      st_next.outData = st_reg.mem[st_reg.rptr];
      st_next.rptr = AW'(st_reg.rptr + 1'b1);
    end
    if (push)
    begin
      st_next.mem[st_reg.wptr] = inPort.data;
      st_next.wptr = AW'(st_reg.wptr + 1'b1);
    end
    st_next.count = (AW+1)'(st_reg.count + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0));
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end
endmodule

// ==== adcrc_top.sv ====
`timescale 1ns/1ns
`include "adcrc_regs.svh"
module adcrc_top #(
  parameter bit HAS_NEG_REF = 1'b1
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic converterPowerOn,
  input wire logic referenceGeneratorOn,
  input wire logic builtinReferenceLevel,
  input wire logic convEnable,
  input wire adcrc_pkg::adcrc_mode_t convMode,
  input wire logic [3:0] startSlot,
  input wire logic [1:0] sampleSourceSel,
  input wire logic sampleSoftware,
  input wire logic [2:0] sampleTrigger,
  input wire logic sampleTimerMode,
  input wire logic [3:0] sampleTicks,
  input wire adcrc_pkg::adcrc_clksel_t convClockSel,
  input wire logic auxTickEn,
  input wire logic subTickEn,
  input wire logic [2:0] convClockDiv,
  input wire logic compAbove,
  input wire logic ctlWrEn,
  input wire logic [3:0] ctlWrSlot,
  input wire logic [7:0] ctlWrData,
  input wire logic [3:0] slotRdAddr,
  output logic [15:0] slotRdData,
  output logic resultValid,
  input wire logic resultReady,
  output logic [15:0] resultData,
  output logic busy,
  output logic coreOn,
  output logic refGenOn,
  output logic refLevelHigh,
  output logic sampleHold,
  output logic [3:0] muxChannel,
  output logic tempDiodeOn,
  output logic [1:0] vrPlusSel,
  output logic vrMinusSel,
  output logic [11:0] sarTrial
);
  import adcrc_pkg::*;

  typedef struct packed {
    adcrc_state_t st;
    logic [3:0] ptr;
    adcrc_slot_ctl_t [`ADCRC_SLOTS-1:0] ctl;
    logic [`ADCRC_SLOTS-1:0][`ADCRC_RESULT_BITS-1:0] res;
    logic [11:0] sar;
    logic [3:0] bitIdx;
    logic [3:0] tickCnt;
    logic [2:0] settle;
    logic [2:0] divCnt;
    logic [2:0] oscCnt;
    logic samplePrev;
    logic [2:0] trigMeta;
    logic [2:0] trigSync;
    logic compMeta;
    logic compSync;
    logic pushValid;
    logic [15:0] pushData;
    logic [15:0] rdData;
    logic busy;
    logic coreOn;
    logic refGenOn;
    logic refLevelHigh;
    logic sampleHold;
    logic [3:0] muxChannel;
    logic tempDiodeOn;
    logic [1:0] vrPlusSel;
    logic vrMinusSel;
  } adcrc_top_state_t;

  adcrc_top_state_t st_reg;
  adcrc_top_state_t st_next;
  logic oscTick;
  logic srcTick;
  logic convTick;
  logic sampleSig;
  logic sampleRise;
  adcrc_slot_ctl_t curCtl;

  adcrc_stream_if #(.W(`ADCRC_FIFO_WIDTH)) pushIf();

  // Codes above the last internal input fold onto half supply
  function automatic logic [3:0] chanMap(input logic [3:0] ch);
    chanMap = (ch > `ADCRC_CH_HALF_SUPPLY) ? `ADCRC_CH_HALF_SUPPLY : ch;
  endfunction

  // Upper reference: 0 supply, 1 internal, 2 and 3 external
  function automatic logic [1:0] plusDecode(input logic [2:0] sref);
    unique case (sref[1:0])
      2'b00: plusDecode = 2'h0;
      2'b01: plusDecode = 2'h1;
      2'b10, 2'b11: plusDecode = 2'h2;
    endcase
  endfunction

  // Conversion clock source as a one-cycle enable
  // clock source select
  assign oscTick = (st_reg.oscCnt == `ADCRC_OSC_DIV - 3'h1);
  always_comb
  begin
    unique case (convClockSel)
      CLK_OSC: srcTick = oscTick;
      CLK_MCLK: srcTick = 1'b1;
      CLK_AUX: srcTick = auxTickEn;
      CLK_SUB: srcTick = subTickEn;
    endcase
  end
  assign convTick = srcTick && (st_reg.divCnt == convClockDiv);

  // Selected sample source; trigger pins are read only after two flops
  // sample source select
  assign sampleSig = (sampleSourceSel == 2'h0) ? sampleSoftware
                   : st_reg.trigSync[sampleSourceSel - 2'h1];
  assign sampleRise = sampleSig && !st_reg.samplePrev;
  assign curCtl = st_reg.ctl[st_reg.ptr];

  assign pushIf.valid = st_reg.pushValid;
  assign pushIf.data = st_reg.pushData;

  always_comb
  begin
    logic [11:0] finalCode;
    finalCode = st_reg.sar;
    st_next = st_reg;
    st_next.trigMeta = sampleTrigger;
    st_next.trigSync = st_reg.trigMeta;
    st_next.compMeta = compAbove;
    st_next.compSync = st_reg.compMeta;
    st_next.samplePrev = sampleSig;
    st_next.oscCnt = oscTick ? 3'h0 : 3'(st_reg.oscCnt + 3'h1);
    if (srcTick)
    begin
      st_next.divCnt = (st_reg.divCnt == convClockDiv) ? 3'h0 : 3'(st_reg.divCnt + 3'h1);
    end
    if (ctlWrEn)
    begin
      st_next.ctl[ctlWrSlot] = ctlWrData;
    end
    st_next.rdData = {4'h0, st_reg.res[slotRdAddr]};

    unique case (st_reg.st)
      ST_IDLE:
      begin
        st_next.ptr = startSlot;
        if (convEnable && sampleRise)
        begin
          st_next.st = ST_SAMPLE;
          st_next.tickCnt = sampleTicks;
        end
      end
      ST_ARM:
      begin
        if (!convEnable)
        begin
          st_next.st = ST_IDLE;
        end
        else if (sampleRise)
        begin
          st_next.st = ST_SAMPLE;
          st_next.tickCnt = sampleTicks;
        end
      end
      ST_SAMPLE:
      begin
        if (sampleTimerMode)
        begin
          if (convTick)
          begin
            if (st_reg.tickCnt == 4'h0)
            begin
              st_next.st = ST_CONVERT;
            end
            else
            begin
              st_next.tickCnt = 4'(st_reg.tickCnt - 4'h1);
            end
          end
        end
        else if (!sampleSig)
        begin
          st_next.st = ST_CONVERT;
        end
        if (st_next.st == ST_CONVERT)
        begin
          st_next.sar = `ADCRC_SAR_MID;
          st_next.bitIdx = `ADCRC_SAR_MSB_IDX;
          st_next.settle = 3'(`ADCRC_SETTLE_CYC);
        end
      end
      ST_CONVERT:
      begin
        // binary search clamps at 0 and 4095
        if (st_reg.settle != 3'h0)
        begin
          st_next.settle = 3'(st_reg.settle - 3'h1);
        end
        else if (convTick)
        begin
          if (!st_reg.compSync)
          begin
            finalCode[st_reg.bitIdx] = 1'b0;
          end
          st_next.sar = finalCode;
          if (st_reg.bitIdx == 4'h0)
          begin
            st_next.res[st_reg.ptr] = finalCode;
            st_next.pushValid = 1'b1;
            st_next.pushData = {st_reg.ptr, finalCode};
            st_next.st = ST_STORE;
          end
          else
          begin
            st_next.sar[st_reg.bitIdx - 4'h1] = 1'b1;
            st_next.bitIdx = 4'(st_reg.bitIdx - 4'h1);
            st_next.settle = 3'(`ADCRC_SETTLE_CYC);
          end
        end
      end
      ST_STORE:
      begin
        // Holding here lets a full stream stall the converter
        if (pushIf.ready)
        begin
          st_next.pushValid = 1'b0;
          unique case (convMode)
            MODE_SINGLE: st_next.st = ST_IDLE;
            MODE_REP_SINGLE: st_next.st = ST_ARM;
            MODE_SEQ_ONCE:
            begin
              st_next.st = curCtl.eos ? ST_IDLE : ST_ARM;
              st_next.ptr = 4'(st_reg.ptr + 4'h1);
            end
            MODE_REP_SEQ:
            begin
              st_next.st = ST_ARM;
              st_next.ptr = curCtl.eos ? startSlot : 4'(st_reg.ptr + 4'h1);
            end
          endcase
        end
      end
      default:
      begin
        st_next.st = ST_IDLE;
      end
    endcase

    if (!converterPowerOn)
    begin
      st_next.st = ST_IDLE;
      st_next.pushValid = 1'b0;
    end

    // Channel and reference selects follow the entry of the slot in use
    // channel select
    st_next.muxChannel = chanMap(st_next.ctl[st_next.ptr].chan);
    st_next.sampleHold = (st_next.st == ST_SAMPLE);
    st_next.busy = (st_next.st != ST_IDLE);
    st_next.coreOn = converterPowerOn;
    st_next.tempDiodeOn = converterPowerOn && st_next.busy
                        && (st_next.muxChannel == `ADCRC_CH_TEMP);
    st_next.refGenOn = referenceGeneratorOn || st_next.tempDiodeOn;
    st_next.refLevelHigh = builtinReferenceLevel;
    st_next.vrPlusSel = plusDecode(st_next.ctl[st_next.ptr].sref);
    st_next.vrMinusSel = HAS_NEG_REF && st_next.ctl[st_next.ptr].sref[2];
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Nine-word buffer (eight memory words and the output register) between the converter and the result stream
  adcrc_fifo #(
    .W(`ADCRC_FIFO_WIDTH),
    .DEPTH(`ADCRC_FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .reset_n(reset_n),
    .inPort(pushIf.snk),
    .outValid(resultValid),
    .outReady(resultReady),
    .outData(resultData)
  );

  // Every output below is a field of the state register
  assign slotRdData = st_reg.rdData;
  assign busy = st_reg.busy;
  assign coreOn = st_reg.coreOn;
  assign refGenOn = st_reg.refGenOn;
  assign refLevelHigh = st_reg.refLevelHigh;
  assign sampleHold = st_reg.sampleHold;
  assign muxChannel = st_reg.muxChannel;
  assign tempDiodeOn = st_reg.tempDiodeOn;
  assign vrPlusSel = st_reg.vrPlusSel;
  assign vrMinusSel = st_reg.vrMinusSel;
  assign sarTrial = st_reg.sar;

  property p_diode_ref;
    @(posedge mclk) disable iff (!reset_n)
    tempDiodeOn |-> refGenOn && muxChannel == `ADCRC_CH_TEMP;
  endproperty
  a_diode_ref: assert property (p_diode_ref) else $error("diode on without reference");

  property p_core_off;
    @(posedge mclk) disable iff (!reset_n)
    !converterPowerOn |=> !busy && !coreOn && !sampleHold;
  endproperty
  a_core_off: assert property (p_core_off) else $error("core off but still active");

  property p_ref_off;
    @(posedge mclk) disable iff (!reset_n)
    (!referenceGeneratorOn ##1 !tempDiodeOn) |-> !refGenOn;
  endproperty
  a_ref_off: assert property (p_ref_off) else $error("reference on without request");

  property p_no_neg_pin;
    @(posedge mclk) disable iff (!reset_n)
    (HAS_NEG_REF == 1'b0) |-> !vrMinusSel;
  endproperty
  a_no_neg_pin: assert property (p_no_neg_pin) else $error("lower reference not ground");

  property p_sref_decode;
    @(posedge mclk) disable iff (!reset_n)
    st_reg.st == ST_CONVERT |-> vrPlusSel == plusDecode(curCtl.sref);
  endproperty
  a_sref_decode: assert property (p_sref_decode) else $error("upper reference decode wrong");

  property p_div8;
    @(posedge mclk) disable iff (!reset_n)
    convTick && convClockDiv == 3'h7 && convClockSel == CLK_MCLK
      ##1 (convClockDiv == 3'h7 && convClockSel == CLK_MCLK)[*8]
      |-> convTick && !$past(convTick, 1) && !$past(convTick, 2) && !$past(convTick, 3)
        && !$past(convTick, 4) && !$past(convTick, 5) && !$past(convTick, 6)
        && !$past(convTick, 7);
  endproperty
  a_div8: assert property (p_div8) else $error("divide by eight spacing wrong");

  property p_timed_sample;
    @(posedge mclk) disable iff (!reset_n || !converterPowerOn)
    st_reg.st == ST_SAMPLE && sampleTimerMode && convTick && st_reg.tickCnt == 4'h0
      |=> st_reg.st == ST_CONVERT && st_reg.sar == `ADCRC_SAR_MID;
  endproperty
  a_timed_sample: assert property (p_timed_sample) else $error("timed sample end missed");

  property p_single_stop;
    @(posedge mclk) disable iff (!reset_n)
    st_reg.st == ST_STORE && pushIf.ready && convMode == MODE_SINGLE |=> !busy;
  endproperty
  a_single_stop: assert property (p_single_stop) else $error("single mode did not stop");

  property p_slot_read;
    @(posedge mclk) disable iff (!reset_n)
    1'b1 |=> slotRdData == {4'h0, $past(st_reg.res[slotRdAddr])};
  endproperty
  a_slot_read: assert property (p_slot_read) else $error("slot read data wrong");

  property p_store_slot;
    @(posedge mclk) disable iff (!reset_n)
    $rose(st_reg.pushValid) |-> st_reg.res[st_reg.pushData[15:12]] == st_reg.pushData[11:0];
  endproperty
  a_store_slot: assert property (p_store_slot) else $error("slot and stream disagree");
endmodule

// ==== adcrc_analog_model.sv ====
`timescale 1ns/1ns
module adcrc_analog_model (
  input wire logic coreOn,
  input wire logic refGenOn,
  input wire logic refLevelHigh,
  input wire logic [3:0] muxChannel,
  input wire logic [1:0] vrPlusSel,
  input wire logic vrMinusSel,
  input wire logic [11:0] sarTrial,
  output logic compAbove
);
  // Board voltages in millivolts, plain values chosen for the bench
  localparam int SUPPLY_MV = 3000;
  localparam int EXT_REF_MV = 2000;
  localparam int NEG_REF_MV = 500;
  localparam int DIODE_MV = 700;

  function automatic int vinOf(input logic [3:0] ch);
    if (ch <= 4'h7)
      return 300 + 350 * int'(ch);
    case (ch)
      4'h8: return EXT_REF_MV;
      4'h9: return NEG_REF_MV;
      4'ha: return DIODE_MV;
      default: return SUPPLY_MV / 2;
    endcase
  endfunction

  // upper reference, nothing from an unpowered generator
  function automatic int vpOf(input logic [1:0] sel, input logic lvl, input logic gen);
    case (sel)
      2'h0: return SUPPLY_MV;
      2'h1: return gen ? (lvl ? 2500 : 1500) : 0;
      default: return EXT_REF_MV;
    endcase
  endfunction

  function automatic int vmOf(input logic sel);
    return sel ? NEG_REF_MV : 0;
  endfunction

  int vin, vp, vm;
  // comparator against the trial level; a dead core answers low
  always_comb
  begin
    vin = vinOf(muxChannel);
    vp = vpOf(vrPlusSel, refLevelHigh, refGenOn);
    vm = vmOf(vrMinusSel);
    if (!coreOn || vp <= vm)
      compAbove = 1'b0;
    else
      compAbove = (4095 * (vin - vm) >= int'(sarTrial) * (vp - vm));
  end
endmodule

// ==== adc_channel_reference_control_test.sv ====
`timescale 1ns/1ns
module adc_channel_reference_control_test;
  import adcrc_pkg::*;
  logic mclk, reset_n, converterPowerOn, referenceGeneratorOn, builtinReferenceLevel;
  logic convEnable, sampleSoftware, sampleTimerMode, compAbove, ctlWrEn, resultReady;
  logic busy, coreOn, refGenOn, refLevelHigh, sampleHold, tempDiodeOn, vrMinusSel;
  logic resultValid;
  logic auxTickEn = 1'b0;
  logic subTickEn = 1'b0;
  adcrc_mode_t convMode;
  adcrc_clksel_t convClockSel;
  logic [3:0] startSlot, sampleTicks, ctlWrSlot, slotRdAddr, muxChannel;
  logic [1:0] sampleSourceSel, vrPlusSel;
  logic [2:0] sampleTrigger, convClockDiv;
  logic [7:0] ctlWrData;
  logic [15:0] slotRdData, resultData;
  logic [11:0] sarTrial;
  int errorCnt = 0;
  int testsRun = 0;
  int tickCnt = 0;
  int tFast, tSlow;
  int holdCyc = 0;

  adcrc_top uut (.*);
  adcrc_analog_model model (.*);

  // Clock
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Slow system clock enables: aux every 2nd cycle, sub every 3rd
  always @(negedge mclk)
  begin
    tickCnt <= tickCnt + 1;
    auxTickEn <= (tickCnt % 2 == 0);
    subTickEn <= (tickCnt % 3 == 0);
  end

  // Running count of sample-phase cycles, read as a difference
  always @(negedge mclk)
  begin
    holdCyc <= holdCyc + int'(sampleHold);
  end

  task automatic finishTest();
    $display("Checks %0d, mismatches %0d", testsRun, errorCnt);
    if (errorCnt == 0 && testsRun > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    testsRun++;
    if (seen !== exp)
    begin
      errorCnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Expected code worked out from the board voltages and the reference decode
  function automatic logic [11:0] expOf(input logic [7:0] d);
    int vin, vp, vm;
    vin = model.vinOf(d[3:0]);
    vp = model.vpOf(d[5:4], builtinReferenceLevel, 1'b1);
    vm = model.vmOf(d[6]);
    if (vin >= vp)
      return 12'hfff;
    if (vin <= vm)
      return 12'h000;
    return 12'(4095 * (vin - vm) / (vp - vm));
  endfunction

  task automatic writeCtl(input logic [3:0] slot, input logic [7:0] d);
    @(negedge mclk);
    ctlWrEn = 1'b1;
    ctlWrSlot = slot;
    ctlWrData = d;
    @(negedge mclk);
    ctlWrEn = 1'b0;
  endtask

  task automatic readSlot(input logic [3:0] slot, input logic [15:0] exp);
    @(negedge mclk);
    slotRdAddr = slot;
    @(negedge mclk);
    check("slot read", slotRdData, exp);
  endtask

  // Rising edge on the selected sample source, held five cycles
  task automatic trig();
    @(negedge mclk);
    if (sampleSourceSel == 2'h0)
      sampleSoftware = 1'b1;
    else
      sampleTrigger[sampleSourceSel - 2'h1] = 1'b1;
    repeat (5) @(negedge mclk);
    sampleSoftware = 1'b0;
    sampleTrigger = 3'h0;
  endtask

  task automatic waitIdle(output int cyc);
    cyc = 0;
    while (busy !== 1'b0 && cyc < 4000)
    begin
      @(negedge mclk);
      cyc++;
    end
    check("busy", {15'h0, busy}, 16'h0);
  endtask

  // Waits for a word; gives a fresh edge if the run waits for one
  task automatic popResult(input logic [3:0] slot, input logic [11:0] code);
    int n;
    // Let an edge pass so ready is never raised where it was just lowered
    @(negedge mclk);
    n = 0;
    while (resultValid !== 1'b1 && n < 1500)
    begin
      if (n == 600)
        trig();
      @(negedge mclk);
      n++;
    end
    check("fifo valid", {15'h0, resultValid}, 16'h1);
    check("fifo word", resultData, {slot, code});
    resultReady = 1'b1;
    @(negedge mclk);
    resultReady = 1'b0;
  endtask

  task automatic convertOne(input logic [3:0] slot, input logic [7:0] d, output int cyc);
    logic [11:0] code;
    code = expOf(d);
    writeCtl(slot, d);
    startSlot = slot;
    trig();
    check("mux", {12'h0, muxChannel}, {12'h0, ((d[3:0] > 4'hb) ? 4'hb : d[3:0])});
    check("diode", {15'h0, tempDiodeOn}, {15'h0, d[3:0] == 4'ha});
    waitIdle(cyc);
    popResult(slot, code);
    readSlot(slot, {4'h0, code});
  endtask

  // Main sequence
  initial
  begin
    {converterPowerOn, referenceGeneratorOn, builtinReferenceLevel, convEnable} = 4'h0;
    {sampleSoftware, ctlWrEn, resultReady} = 3'h0;
    sampleTimerMode = 1'b1;
    {startSlot, sampleTicks, ctlWrSlot, slotRdAddr} = 16'h0000;
    {sampleSourceSel, sampleTrigger, convClockDiv, ctlWrData} = 16'h0000;
    convMode = MODE_SINGLE;
    convClockSel = CLK_MCLK;
    reset_n = 1'b0;
    repeat (6) @(negedge mclk);
    reset_n = 1'b1;
    repeat (3) @(negedge mclk);
    check("reset state", {busy, coreOn, resultValid}, 16'h0);
    readSlot(4'h5, 16'h0000);
    // power up, then wait for core and reference to settle
    converterPowerOn = 1'b1;
    referenceGeneratorOn = 1'b1;
    convEnable = 1'b1;
    repeat (20) @(negedge mclk);
    check("ref on", {coreOn, refGenOn}, 16'h3);
    for (int i = 0; i < 13; i++)
    begin
      builtinReferenceLevel = i[2];
      convertOne(4'(i), {1'b0, 3'(i < 8 ? i : i - 4), 4'(i)}, tFast);
      check("level", {15'h0, refLevelHigh}, {15'h0, i[2]});
    end
    for (int s = 0; s < 4; s++)
    begin
      convClockSel = adcrc_clksel_t'(s);
      convClockDiv = 3'h0;
      convertOne(4'h3, 8'h03, tFast);
      convClockDiv = 3'h7;
      convertOne(4'h3, 8'h03, tSlow);
      check("divide", {15'h0, tSlow > tFast}, 16'h1);
    end
    convClockSel = CLK_MCLK;
    convClockDiv = 3'h0;
    for (int s = 0; s < 8; s++)
    begin
      sampleSourceSel = 2'(s);
      sampleTimerMode = s[2];
      sampleTicks = 4'(s);
      tSlow = holdCyc;
      convertOne(4'h4, 8'h34, tFast);
      if (s > 3)
        check("hold", 16'(holdCyc - tSlow), 16'(s + 1));
    end
    {sampleSourceSel, sampleTimerMode} = 3'h1;
    // Sequence wraps 15 to 0, channel 2 appears twice with other references
    writeCtl(4'he, 8'h12);
    writeCtl(4'hf, 8'h45);
    writeCtl(4'h0, 8'h82);
    startSlot = 4'he;
    for (int m = 0; m < 2; m++)
    begin
      convMode = m ? MODE_REP_SEQ : MODE_SEQ_ONCE;
      trig();
      popResult(4'he, expOf(8'h12));
      popResult(4'hf, expOf(8'h45));
      popResult(4'h0, expOf(8'h82));
      if (m == 1)
        popResult(4'he, expOf(8'h12));
      convEnable = 1'b0;
      waitIdle(tFast);
      check("no extra", {15'h0, resultValid}, 16'h0);
      convEnable = 1'b1;
    end
    // Nine words fill the buffer; the tenth conversion waits in store
    convMode = MODE_REP_SINGLE;
    startSlot = 4'h6;
    writeCtl(4'h6, 8'h06);
    for (int k = 0; k < 10; k++)
    begin
      trig();
      repeat (120) @(negedge mclk);
    end
    check("full stall", {resultValid, busy}, 16'h3);
    for (int k = 0; k < 10; k++)
      popResult(4'h6, expOf(8'h06));
    check("drained", {15'h0, resultValid}, 16'h0);
    convEnable = 1'b0;
    waitIdle(tFast);
    convEnable = 1'b1;
    // Core power loss during the sample phase aborts; reference stays up
    convMode = MODE_SINGLE;
    trig();
    converterPowerOn = 1'b0;
    repeat (3) @(negedge mclk);
    check("abort", {busy, coreOn, refGenOn}, 16'h1);
    repeat (100) @(negedge mclk);
    check("abort empty", {15'h0, resultValid}, 16'h0);
    referenceGeneratorOn = 1'b0;
    repeat (2) @(negedge mclk);
    check("ref off", {15'h0, refGenOn}, 16'h0);
    finishTest();
  end

  // Watchdog against a hang
  initial
  begin
    repeat (60000) @(posedge mclk);
    errorCnt++;
    $display("MISMATCH watchdog expected done seen timeout");
    finishTest();
  end
endmodule
